/* File: bench/btg_piezo_model.sv */
`timescale 1ns/1ps
`default_nettype none
module btg_piezo_model (
	input  wire logic        clk,
	input  wire logic        tonePin,
	output var  logic [15:0] lowCnt,
	output var  logic [15:0] perCnt
);
	// ----------------------------------------------------------------
	// load that times each tone period
	// ----------------------------------------------------------------
	logic        pinQ;
	logic [15:0] runCnt;
	logic [15:0] lowRun;
	initial begin
		pinQ = 1'b1;
		runCnt = 16'h0000;
		lowRun = 16'h0000;
		lowCnt = 16'h0000;
		perCnt = 16'h0000;
	end
	// a falling edge closes one period: low part first
	always @(posedge clk) begin
		pinQ <= tonePin;
		if (pinQ && !tonePin) begin
			perCnt <= runCnt;
			lowCnt <= lowRun;
			runCnt <= 16'h0001;
			lowRun <= 16'h0001;
		end else begin
			runCnt <= runCnt + 16'h0001;
			lowRun <= lowRun + {15'h0000, !tonePin};
		end
	end
endmodule // btg_piezo_model
`default_nettype wire

/* File: bench/btg_tone_gen_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "btg_defs.vh"
module btg_tone_sva (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [17:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        slowOscClk,
	input wire logic        tonePin,
	input wire logic        toneActive
);
	// ----------------------------------------------------------------
	// port checks
	// ----------------------------------------------------------------
	// byte addresses are four times the index
	localparam logic [17:0] ACTRL = `BTG_IDX_OUTPUT_CONTROL << 2;
	localparam logic [17:0] ASEL  = `BTG_IDX_TONE_SELECT << 2;
	wire logic mapped;
	assign mapped = paddr == ACTRL || paddr == ASEL;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// control write, then a quiet stretch
	sequence sCtrlWr;
		psel && penable && pwrite && paddr == ACTRL;
	endsequence
	sequence sIdle;
		!toneActive [*3];
	endsequence
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_read_zeros: assert property (psel && penable && !pwrite |-> prdata[31:7] == 25'h0)
		else $error("unused read bits not zero");
	a_write_only: assert property (psel && penable && !pwrite && paddr == ACTRL |->
		!prdata[2] && !prdata[6]) else $error("write-only bit reads one");
	a_idle_high: assert property (sIdle |-> tonePin)
		else $error("pin low while tone off");
	a_cont_on: assert property (sCtrlWr ##0 pwdata[0] |=> toneActive)
		else $error("continuous enable not active");
	a_stop_now: assert property (sCtrlWr ##0 (pwdata[6] && !pwdata[0]) |=>
		!toneActive ##[0:2] tonePin) else $error("forced stop late");
	a_trig_busy: assert property (sCtrlWr ##0 (pwdata[5] && !pwdata[6] && !toneActive)
		|=> toneActive [*2]) else $error("trigger did not start one-shot");
endmodule // btg_tone_sva
bind btg_tone_gen btg_tone_sva u_sva (
	.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .slowOscClk(slowOscClk), .tonePin(tonePin),
	.toneActive(toneActive)
);
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "btg_defs.vh"
module tb_top;
	// ----------------------------------------------------------------
	// bench
	// ----------------------------------------------------------------
	localparam logic [17:0] ACTRL = `BTG_IDX_OUTPUT_CONTROL << 2;
	localparam logic [17:0] ASEL  = `BTG_IDX_TONE_SELECT << 2;
	logic        clk, rst, psel, penable, pwrite, osc, errv;
	logic [17:0] paddr;
	logic [31:0] pwdata, rdv;
	wire  [31:0] prdata;
	wire         pready, pslverr, tonePin, toneActive;
	wire  [15:0] lowCnt, perCnt;
	int          fails, tests_run;
	btg_tone_gen u_dut (
		.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .slowOscClk(osc), .tonePin(tonePin),
		.toneActive(toneActive)
	);
	btg_piezo_model u_piezo (.clk(clk), .tonePin(tonePin), .lowCnt(lowCnt), .perCnt(perCnt));
	// system clock and a fast, unrelated oscillator
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		osc = 1'b0;
		#7;
		forever #80 osc = ~osc;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one transfer: setup, access until pready, one idle cycle
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 100) begin
			check("pready", 32'h0, 32'h1);
			results();
		end
	endtask
	task automatic wr(input logic [17:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [17:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check("read", rdv, exp);
	endtask
	// low ticks and period ticks of the last full period
	task automatic toneChk(input logic [2:0] f, input logic [2:0] l);
		logic [15:0] tk;
		tk = f[2] ? 16'h0008 : 16'h0004;
		check("low", lowCnt, ((f[1] ? 16'h000c : 16'h0008) - {13'h0, l}) * tk);
		check("period", perCnt, (16'h0010 + {12'h0, f[1:0], 2'b00}) * tk);
	endtask
	task automatic shotLen(input int lo, input int hi);
		int n;
		n = 0;
		while (toneActive === 1'b1 && n < 50000) begin
			@(posedge clk);
			n++;
		end
		check("shot length", n >= lo && n <= hi, 32'h1);
		if (n >= 50000) results();
	endtask
	task automatic t_regs;
		check("pin", tonePin, 32'h1);
		rd(ACTRL, 32'h0);
		rd(ASEL, 32'h0);
		wr(ASEL, 32'hffffffff);
		rd(ASEL, 32'h77);
		wr(18'h3fd58, 32'hff);
		check("unmapped err", errv, 32'h1);
		rd(18'h3fd58, 32'h0);
		wr(ACTRL, 32'h18);
		rd(ACTRL, 32'h18);
		$display("registers done");
	endtask
	task automatic t_tone;
		int bad;
		wr(ACTRL, 32'h1);
		for (int i = 0; i < 8; i++) begin
			wr(ASEL, {25'h0, ~i[2:0], 1'b0, i[2:0]});
			repeat (1000) @(posedge clk);
			toneChk(i[2:0], ~i[2:0]);
		end
		wr(ACTRL, 32'h0);
		repeat (3) @(posedge clk);
		bad = 0;
		repeat (200) begin
			@(posedge clk);
			if (tonePin !== 1'b1) bad++;
		end
		check("idle pin", bad, 32'h0);
		$display("tones done");
	endtask
	task automatic t_env;
		wr(ASEL, 32'h70);
		wr(ACTRL, 32'h3);
		repeat (300) @(posedge clk);
		toneChk(3'h0, 3'h0);
		repeat (17000) @(posedge clk);
		toneChk(3'h0, 3'h1);
		wr(ACTRL, 32'h7);
		repeat (300) @(posedge clk);
		toneChk(3'h0, 3'h0);
		rd(ACTRL, 32'h3);
		wr(ACTRL, 32'h0);
		$display("envelope done");
	endtask
	task automatic t_shot;
		wr(ASEL, 32'h30);
		wr(ACTRL, 32'h1);
		wr(ACTRL, 32'h21);
		rd(ACTRL, 32'h1);
		wr(ACTRL, 32'h60);
		rd(ACTRL, 32'h0);
		wr(ACTRL, 32'h22);
		rd(ACTRL, 32'h20);
		repeat (3000) @(posedge clk);
		toneChk(3'h0, 3'h3);
		wr(ACTRL, 32'h40);
		check("stopped", toneActive, 32'h0);
		rd(ACTRL, 32'h0);
		wr(ACTRL, 32'h20);
		repeat (5000) @(posedge clk);
		wr(ACTRL, 32'h20);
		shotLen(8100, 9400);
		rd(ACTRL, 32'h0);
		wr(ACTRL, 32'h30);
		shotLen(32700, 33900);
		$display("one-shot done");
	endtask
	// reset, scenarios, verdict
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 18'h0;
		pwdata = 32'h0;
		fails = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_tone();
		t_env();
		t_shot();
		wr(ACTRL, 32'h0);
		results();
	end
endmodule // tb_top
`default_nettype wire

/* File: inc/btg_defs.vh */
`ifndef BTG_DEFS_VH
`define BTG_DEFS_VH

// ----------------------------------------------------------------
// register map (printed offsets are indices, byte address = 4 x index)
// ----------------------------------------------------------------
`define BTG_IDX_OUTPUT_CONTROL 18'h0ff54
`define BTG_IDX_TONE_SELECT    18'h0ff55
`define BTG_ADDR_WIDTH         18

// ----------------------------------------------------------------
// output control fields
// ----------------------------------------------------------------
`define BTG_BIT_CONT_ENABLE    0
`define BTG_BIT_ENV_ENABLE     1
`define BTG_BIT_ENV_RESTART    2
`define BTG_BIT_DECAY_STEP     3
`define BTG_BIT_SHOT_WIDTH     4
`define BTG_BIT_SHOT_TRIGGER   5
`define BTG_BIT_SHOT_STOP      6

// ----------------------------------------------------------------
// tone select fields
// ----------------------------------------------------------------
`define BTG_FREQ_LSB           0
`define BTG_FREQ_MSB           2
`define BTG_LEVEL_LSB          4
`define BTG_LEVEL_MSB          6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BTG_RST_FREQ           3'h0
`define BTG_RST_LEVEL          3'h0
`define BTG_RST_BIT            1'b0

// ----------------------------------------------------------------
// timing (slow oscillator and derived rates)
// ----------------------------------------------------------------
`define BTG_OSC_HZ             32768
`define BTG_SYNC_HZ            256
`define BTG_SHOT_SHORT_US      31250
`define BTG_SHOT_LONG_US       125000
`define BTG_STEP_SHORT_US      62500
`define BTG_STEP_LONG_US       125000
`define BTG_US_PER_S           1000000
`define BTG_LEVEL_LAST         3'h7

`endif

/* File: rtl/btg_tone_gen.v */
`timescale 1ns/1ps
`default_nettype none
`include "btg_defs.vh"

module btg_tone_gen (
	input  wire        clk,
	input  wire        rst,
	input  wire [17:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire [31:0] prdata,
	output wire        pslverr,
	input  wire        slowOscClk,
	output wire        tonePin,
	output wire        toneActive
);

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam [17:0] ADDR_CTRL = `BTG_IDX_OUTPUT_CONTROL << 2;
	localparam [17:0] ADDR_SEL  = `BTG_IDX_TONE_SELECT << 2;
	localparam integer OSC_PER_SYNC = `BTG_OSC_HZ / `BTG_SYNC_HZ;
	localparam integer SYNC_LAST_I  = OSC_PER_SYNC - 1;
	localparam integer SHOT_SHORT_I =
		(`BTG_SHOT_SHORT_US * `BTG_SYNC_HZ) / `BTG_US_PER_S;
	localparam integer SHOT_LONG_I  =
		(`BTG_SHOT_LONG_US * `BTG_SYNC_HZ) / `BTG_US_PER_S;
	localparam integer STEP_SHORT_I =
		(`BTG_STEP_SHORT_US * `BTG_SYNC_HZ) / `BTG_US_PER_S;
	localparam integer STEP_LONG_I  =
		(`BTG_STEP_LONG_US * `BTG_SYNC_HZ) / `BTG_US_PER_S;

	// counts fit their counters; cut to width on purpose
	localparam [6:0] SYNC_LAST  = SYNC_LAST_I[6:0];
	localparam [5:0] SHOT_SHORT = SHOT_SHORT_I[5:0];
	localparam [5:0] SHOT_LONG  = SHOT_LONG_I[5:0];
	localparam [5:0] STEP_SHORT = STEP_SHORT_I[5:0];
	localparam [5:0] STEP_LONG  = STEP_LONG_I[5:0];

	// one-shot states
	localparam [1:0] SHOT_IDLE    = 2'h0;
	localparam [1:0] SHOT_PENDING = 2'h1;
	localparam [1:0] SHOT_RUN     = 2'h2;

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	// period length in ticks for a frequency group
	function [4:0] periodLen;
		input [1:0] grp;
		begin
			periodLen = 5'h10 + {1'b0, grp, 2'h0};
		end
	endfunction

	// low-time ticks for a group and a level
	function [4:0] lowTicks;
		input [1:0] grp;
		input [2:0] lvl;
		begin
			if (grp[1]) begin
				lowTicks = 5'h0c - {2'h0, lvl};
			end else begin
				lowTicks = 5'h08 - {2'h0, lvl};
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg        contEnable_reg;
	reg        envEnable_reg;
	reg        decayStep_reg;
	reg        shotWidth_reg;
	reg [2:0]  freqSel_reg;
	reg [2:0]  levelSel_reg;
	reg [31:0] prdata_reg;
	reg        pslverr_reg;
	reg        sync1_reg;
	reg        sync2_reg;
	reg        sync3_reg;
	reg        oscLevel_reg;
	reg [6:0]  syncDiv_reg;
	reg [4:0]  periodCnt_reg;
	reg        halfTick_reg;
	reg        toneOut_reg;
	reg        pin_reg;
	reg [1:0]  shotState_reg;
	reg [5:0]  shotCnt_reg;
	reg [2:0]  envLevel_reg;
	reg [5:0]  envCnt_reg;

	wire       writeAcc;
	wire       readSetup;
	wire       wrCtrl;
	wire       wrSel;
	wire       oscChange;
	wire       oscRise;
	wire       syncTick;
	wire       toneTick;
	wire [1:0] freqGrp;
	wire [2:0] dutyLevel;
	wire [4:0] perLen;
	wire [4:0] lowLen;
	wire       trigWrite;
	wire       stopWrite;
	wire       shotBusy;
	wire       contStart;
	wire [5:0] stepLen;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// writes commit at the access edge, reads capture at setup
	assign writeAcc  = psel & penable & pwrite;
	assign readSetup = psel & ~penable;
	assign wrCtrl    = writeAcc & (paddr == ADDR_CTRL);
	assign wrSel     = writeAcc & (paddr == ADDR_SEL);
	assign pready    = 1'b1;
	assign prdata    = prdata_reg;
	assign pslverr   = pslverr_reg;

	// trigger and stop strobes from a control write
	assign trigWrite = wrCtrl & pwdata[`BTG_BIT_SHOT_TRIGGER];
	assign stopWrite = wrCtrl & pwdata[`BTG_BIT_SHOT_STOP];

	// read data and error captured in the setup cycle
	always @(posedge clk) begin
		if (rst) begin
			prdata_reg  <= 32'h0;
			pslverr_reg <= 1'b0;
		end else if (readSetup) begin
			pslverr_reg <= (paddr != ADDR_CTRL) && (paddr != ADDR_SEL);
			if (paddr == ADDR_CTRL) begin
				prdata_reg <= {24'h0, 1'b0, 1'b0, shotBusy, shotWidth_reg,
					decayStep_reg, 1'b0, envEnable_reg, contEnable_reg};
			end else if (paddr == ADDR_SEL) begin
				prdata_reg <= {24'h0, 1'b0, levelSel_reg, 1'b0, freqSel_reg};
			end else begin
				prdata_reg <= 32'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	// software fields; trigger write forces envelope off
	always @(posedge clk) begin
		if (rst) begin
			contEnable_reg <= `BTG_RST_BIT;
			envEnable_reg  <= `BTG_RST_BIT;
			decayStep_reg  <= `BTG_RST_BIT;
			shotWidth_reg  <= `BTG_RST_BIT;
			freqSel_reg    <= `BTG_RST_FREQ;
			levelSel_reg   <= `BTG_RST_LEVEL;
		end else begin
			if (wrCtrl) begin
				contEnable_reg <= pwdata[`BTG_BIT_CONT_ENABLE];
				decayStep_reg  <= pwdata[`BTG_BIT_DECAY_STEP];
				shotWidth_reg  <= pwdata[`BTG_BIT_SHOT_WIDTH];
				if (pwdata[`BTG_BIT_SHOT_TRIGGER]) begin
					envEnable_reg <= 1'b0;
				end else begin
					envEnable_reg <= pwdata[`BTG_BIT_ENV_ENABLE];
				end
			end
			if (wrSel) begin
				freqSel_reg  <= pwdata[`BTG_FREQ_MSB:`BTG_FREQ_LSB];
				levelSel_reg <= pwdata[`BTG_LEVEL_MSB:`BTG_LEVEL_LSB];
			end
		end
	end

	// ----------------------------------------------------------------
	// slow oscillator synchroniser
	// ----------------------------------------------------------------
	// three stages; level accepted once stages two and three agree
	always @(posedge clk) begin
		if (rst) begin
			sync1_reg    <= 1'b0;
			sync2_reg    <= 1'b0;
			sync3_reg    <= 1'b0;
			oscLevel_reg <= 1'b0;
		end else begin
			sync1_reg <= slowOscClk;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			if (sync2_reg == sync3_reg) begin
				oscLevel_reg <= sync3_reg;
			end
		end
	end

	// both edges give 65536 Hz ticks, rising edges 32768 Hz
	assign oscChange = (sync2_reg == sync3_reg) && (sync3_reg != oscLevel_reg);
	assign oscRise   = oscChange & sync3_reg;

	// ----------------------------------------------------------------
	// 256 Hz timing divider
	// ----------------------------------------------------------------
	// free-running divide of the oscillator down to the sync rate
	always @(posedge clk) begin
		if (rst) begin
			syncDiv_reg <= 7'h0;
		end else if (oscRise) begin
			if (syncDiv_reg == SYNC_LAST) begin
				syncDiv_reg <= 7'h0;
			end else begin
				syncDiv_reg <= syncDiv_reg + 7'h1;
			end
		end
	end

	assign syncTick = oscRise && (syncDiv_reg == SYNC_LAST);

	// ----------------------------------------------------------------
	// tone period counter
	// ----------------------------------------------------------------
	// high frequencies tick on each edge, low ones on every second
	assign freqGrp   = freqSel_reg[1:0];
	assign toneTick  = freqSel_reg[2] ? (oscChange & halfTick_reg) : oscChange;
	assign dutyLevel = (envEnable_reg && contEnable_reg) ? envLevel_reg : levelSel_reg;
	assign perLen    = periodLen(freqGrp);
	assign lowLen    = lowTicks(freqGrp, dutyLevel);

	// half-rate toggle for the lower octave
	always @(posedge clk) begin
		if (rst) begin
			halfTick_reg <= 1'b0;
		end else if (oscChange) begin
			halfTick_reg <= ~halfTick_reg;
		end
	end

	// free-running counter; enabling mid-period may clip a half period
	always @(posedge clk) begin
		if (rst) begin
			periodCnt_reg <= 5'h0;
		end else if (toneTick) begin
			if (periodCnt_reg >= perLen - 5'h1) begin
				periodCnt_reg <= 5'h0;
			end else begin
				periodCnt_reg <= periodCnt_reg + 5'h1;
			end
		end
	end

	// low for the first lowLen ticks of each period
	always @(posedge clk) begin
		if (rst) begin
			toneOut_reg <= 1'b1;
		end else begin
			toneOut_reg <= (periodCnt_reg >= lowLen);
		end
	end

	// ----------------------------------------------------------------
	// one-shot sequencer
	// ----------------------------------------------------------------
	assign shotBusy = (shotState_reg != SHOT_IDLE);

	// pending waits for 256 Hz, run counts down in 256 Hz ticks
	always @(posedge clk) begin
		if (rst) begin
			shotState_reg <= SHOT_IDLE;
			shotCnt_reg   <= 6'h0;
		end else begin
			case (shotState_reg)
			SHOT_IDLE: begin
				if (trigWrite && !stopWrite && !contEnable_reg) begin
					shotState_reg <= SHOT_PENDING;
				end
			end
			SHOT_PENDING: begin
				if (stopWrite) begin
					shotState_reg <= SHOT_IDLE;
				end else if (syncTick) begin
					shotState_reg <= SHOT_RUN;
					shotCnt_reg   <= shotWidth_reg ? SHOT_LONG : SHOT_SHORT;
				end
			end
			SHOT_RUN: begin
				if (stopWrite) begin
					shotState_reg <= SHOT_IDLE;
				end else if (trigWrite && !contEnable_reg) begin
					// keep sounding; one extra count covers the partial 256 Hz slot
					shotCnt_reg <= pwdata[`BTG_BIT_SHOT_WIDTH] ?
						SHOT_LONG + 6'h1 : SHOT_SHORT + 6'h1;
				end else if (syncTick) begin
					if (shotCnt_reg == 6'h1) begin
						shotState_reg <= SHOT_IDLE;
					end
					shotCnt_reg <= shotCnt_reg - 6'h1;
				end
			end
			default: begin
				shotState_reg <= SHOT_IDLE;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// envelope sequencer
	// ----------------------------------------------------------------
	assign contStart = wrCtrl && pwdata[`BTG_BIT_CONT_ENABLE] && !contEnable_reg;
	assign stepLen   = decayStep_reg ? STEP_LONG : STEP_SHORT;

	// level 0 at start or restart, one step per interval, hold at 7
	always @(posedge clk) begin
		if (rst) begin
			envLevel_reg <= 3'h0;
			envCnt_reg   <= 6'h0;
		end else if (contStart ||
			(wrCtrl && pwdata[`BTG_BIT_ENV_RESTART] && envEnable_reg)) begin
			envLevel_reg <= 3'h0;
			envCnt_reg   <= 6'h0;
		end else if (envEnable_reg && contEnable_reg && syncTick) begin
			if (envCnt_reg >= stepLen - 6'h1) begin
				envCnt_reg <= 6'h0;
				if (envLevel_reg != `BTG_LEVEL_LAST) begin
					envLevel_reg <= envLevel_reg + 3'h1;
				end
			end else begin
				envCnt_reg <= envCnt_reg + 6'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// tone while continuous or one-shot runs, otherwise steady high
	always @(posedge clk) begin
		if (rst) begin
			pin_reg <= 1'b1;
		end else if (contEnable_reg || shotState_reg == SHOT_RUN) begin
			pin_reg <= toneOut_reg;
		end else begin
			pin_reg <= 1'b1;
		end
	end

	assign tonePin    = pin_reg;
	assign toneActive = contEnable_reg | shotBusy;

endmodule // btg_tone_gen
`default_nettype wire
